//--- hw/esp_dev.sv
// Functional notes
// - break is start, twelve zeros, stop
// - send-break plus enable: write starts break
// - break ignores written data, sends zeros
// - hardware clears send-break after break stop
// - next byte queues during break, follows it
// - master writes 0x55 sync after dummy
// - shift-empty status works same during break
// - buffer-empty flag shows room for data
// - received break: done, framing error, zero
// - auto-wake: two edges, flag, then byte
// - auto-baud bit may be set before sleep
// - slave mode: always receiving unless overrun, single ignored
// - word in sleep lands, wakes if enabled
// - slave select: clocked, enable, not master
// - completion sets flag, interrupt if enabled
// - ninth bit in status, eight in data
// - overrun held until continuous/port cleared
`timescale 1ns/100ps
`default_nettype none
module esp_dev
   import esp_pkg::*;
#(
   parameter int FIFO_DEPTH = TXF_DEPTH
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // software port
   input  wire logic [ADDR_W-1:0] sw_addr,
   input  wire logic [REG_W-1:0]  sw_wdata,
   input  wire logic              sw_wr,
   input  wire logic              sw_rd,
   output logic [REG_W-1:0]       sw_rdata,
   // events
   output logic                   rx_irq,
   output logic                   tx_room,
   // serial link
   esp_link_if.dev                link
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CTL_W-1:0] ctl;
      logic [REG_W-1:0] baud;
      logic             brk_pend;
      esp_tx_state_type tx_st;
      logic [7:0]       tx_sh;
      logic             tx_brk;
      logic [REG_W-1:0] tx_cnt;
      logic [3:0]       tx_bit;
      logic             tx_pin;
      esp_rx_state_type rx_st;
      logic [8:0]       rx_sh;
      logic [REG_W-1:0] rx_cnt;
      logic [3:0]       rx_bit;
      logic [7:0]       rx_hold;
      logic             rx_ninth;
      logic             rx_full;
      logic             framing_error;
      logic             overrun_error;
      logic [1:0]       dt_s;
      logic             dt_q;
      logic [1:0]       ck_s;
      logic             ck_q;
      logic [REG_W-1:0] rdata;
      logic             irq;
      logic             room;
   } esp_dev_st_type;

   esp_dev_st_type   s_r;
   esp_dev_st_type   s_nxt;
   logic             dt;
   logic             fall;
   logic             rise;
   logic             ck_rise;
   logic             slave;
   logic             async_on;
   logic [3:0]       last_bit;
   logic [8:0]       shv;
   logic             done;
   logic             fe;
   logic [8:0]       word;
   logic [REG_W-1:0] stat;
   logic             f_in_valid;
   logic             f_in_ready;
   logic [TXF_W-1:0] f_in_data;
   logic             f_out_valid;
   logic             f_out_ready;
   logic [TXF_W-1:0] f_out_data;

   // lines up a received word: ninth bit on top, data below
   function automatic logic [8:0] align(input logic [8:0] sh, input logic nine);
      return nine ? sh : {1'b0, sh[8:1]};
   endfunction

   assign sw_rdata    = s_r.rdata;
   assign rx_irq      = s_r.irq;
   assign tx_room     = s_r.room;
   assign link.ser_tx = s_r.tx_pin;

   // ----------------------------------------------------------------
   // transmit queue
   // ----------------------------------------------------------------
   esp_fifo #(.W(TXF_W), .D(FIFO_DEPTH)) u_txq (
      .clock     (clock),
      .reset_n   (reset_n),
      .flush     (!s_r.ctl[BIT_PORT_EN]),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt      = s_r;
      s_nxt.dt_s = {s_r.dt_s[0], link.ser_dt};
      s_nxt.dt_q = s_r.dt_s[1];
      s_nxt.ck_s = {s_r.ck_s[0], link.ser_ck};
      s_nxt.ck_q = s_r.ck_s[1];
      dt       = s_r.dt_s[1];
      fall     = s_r.dt_q & ~dt;
      rise     = ~s_r.dt_q & dt;
      ck_rise  = ~s_r.ck_q & s_r.ck_s[1];
      slave    = s_r.ctl[BIT_PORT_EN] & s_r.ctl[BIT_CLOCKED] & ~s_r.ctl[BIT_CLK_MASTER];
      async_on = s_r.ctl[BIT_PORT_EN] & ~s_r.ctl[BIT_CLOCKED] & s_r.ctl[BIT_CONT_RX] & ~s_r.overrun_error;
      last_bit = s_r.ctl[BIT_NINE_EN] ? NINE_LAST : DATA_LAST;
      shv      = {dt, s_r.rx_sh[8:1]};
      done     = 1'b0;
      fe       = 1'b0;
      word     = align(shv, s_r.ctl[BIT_NINE_EN]);

      // software side; the auto-baud bit is only held for software
      if (sw_wr && sw_addr == ADDR_CTRL) begin
         s_nxt.ctl = sw_wdata[CTL_W-1:0];
      end
      if (sw_wr && sw_addr == ADDR_BAUD) begin
         s_nxt.baud = sw_wdata;
      end
      stat                    = '0;
      stat[ST_TX_SHIFT_EMPTY] = s_r.tx_st == TX_IDLE;
      stat[ST_TX_BUF_EMPTY]   = f_in_ready;
      stat[ST_RX_DONE]        = s_r.rx_full;
      stat[ST_FRAME_ERR]      = s_r.framing_error;
      stat[ST_OVERRUN]        = s_r.overrun_error;
      stat[ST_NINTH]          = s_r.rx_ninth;
      s_nxt.rdata = '0;
      if (sw_rd) begin
         case (sw_addr)
            ADDR_CTRL: s_nxt.rdata = {{(REG_W-CTL_W){1'b0}}, s_r.ctl};
            ADDR_STAT: s_nxt.rdata = stat;
            ADDR_RXD:  s_nxt.rdata = {8'h00, s_r.rx_hold};
            ADDR_BAUD: s_nxt.rdata = s_r.baud;
            default:   s_nxt.rdata = '0;
         endcase
      end
      // reading the data frees the holding register; a new word in the same cycle wins
      if (sw_rd && sw_addr == ADDR_RXD) begin
         s_nxt.rx_full = 1'b0;
         s_nxt.framing_error    = 1'b0;
      end

      // only the first write after send-break is armed marks a break; later ones queue
      f_in_valid = sw_wr && sw_addr == ADDR_TXD && s_r.ctl[BIT_TX_EN] && s_r.ctl[BIT_PORT_EN];
      f_in_data  = {s_r.ctl[BIT_SEND_BREAK] & ~s_r.brk_pend, sw_wdata[7:0]};
      if (f_in_valid && f_in_ready && f_in_data[8]) begin
         s_nxt.brk_pend = 1'b1;
      end
      f_out_ready = s_r.tx_st == TX_IDLE && s_r.ctl[BIT_TX_EN] && s_r.ctl[BIT_PORT_EN];

      // ----------------------------------------------------------------
      // transmitter, one bit per baud period for both kinds
      // ----------------------------------------------------------------
      case (s_r.tx_st)
         TX_IDLE: begin
            s_nxt.tx_pin = 1'b1;
            if (f_out_valid && f_out_ready) begin
               s_nxt.tx_sh  = f_out_data[7:0];
               s_nxt.tx_brk = f_out_data[8];
               s_nxt.tx_cnt = s_r.baud;
               s_nxt.tx_pin = 1'b0;
               s_nxt.tx_st  = TX_START;
            end
         end
         TX_START: begin
            s_nxt.tx_cnt = s_r.tx_cnt - 1'b1;
            if (s_r.tx_cnt == '0) begin
               s_nxt.tx_st  = TX_DATA;
               s_nxt.tx_cnt = s_r.baud;
               s_nxt.tx_bit = '0;
               s_nxt.tx_pin = s_r.tx_brk ? 1'b0 : s_r.tx_sh[0];
            end
         end
         TX_DATA: begin
            s_nxt.tx_cnt = s_r.tx_cnt - 1'b1;
            if (s_r.tx_cnt == '0) begin
               s_nxt.tx_cnt = s_r.baud;
               if (s_r.tx_bit == (s_r.tx_brk ? BREAK_LAST : DATA_LAST)) begin
                  s_nxt.tx_st  = TX_STOP;
                  s_nxt.tx_pin = 1'b1;
               end else begin
                  s_nxt.tx_bit = s_r.tx_bit + 1'b1;
                  s_nxt.tx_sh  = {1'b0, s_r.tx_sh[7:1]};
                  s_nxt.tx_pin = s_r.tx_brk ? 1'b0 : s_r.tx_sh[1];
               end
            end
         end
         TX_STOP: begin
            s_nxt.tx_cnt = s_r.tx_cnt - 1'b1;
            if (s_r.tx_cnt == '0) begin
               s_nxt.tx_st = TX_IDLE;
               if (s_r.tx_brk) begin
                  s_nxt.ctl[BIT_SEND_BREAK] = 1'b0;
                  s_nxt.brk_pend            = 1'b0;
                  s_nxt.tx_brk              = 1'b0;
               end
            end
         end
         default: s_nxt.tx_st = TX_IDLE;
      endcase

      // ----------------------------------------------------------------
      // receiver
      // ----------------------------------------------------------------
      case (s_r.rx_st)
         RX_IDLE: begin
            if (slave) begin
               // slave mode ignores continuous and single receive bits
               if (ck_rise && !s_r.overrun_error) begin
                  s_nxt.rx_sh = shv;
                  if (s_r.rx_bit == last_bit) begin
                     s_nxt.rx_bit = '0;
                     done         = 1'b1;
                  end else begin
                     s_nxt.rx_bit = s_r.rx_bit + 1'b1;
                  end
               end
            end else if (async_on && fall) begin
               s_nxt.rx_st  = s_r.ctl[BIT_WAKE_EN] ? RX_WAKE : RX_START;
               s_nxt.rx_cnt = s_r.baud >> 1;
            end
         end
         RX_WAKE: begin
            if (!async_on) begin
               s_nxt.rx_st = RX_IDLE;
            end else if (rise) begin
               s_nxt.rx_full              = 1'b1;
               s_nxt.ctl[BIT_WAKE_EN]     = 1'b0;
               s_nxt.rx_st                = RX_IDLE;
            end
         end
         RX_START: begin
            s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
            if (s_r.rx_cnt == '0) begin
               s_nxt.rx_st  = dt ? RX_IDLE : RX_DATA;
               s_nxt.rx_cnt = s_r.baud;
               s_nxt.rx_bit = '0;
            end
         end
         RX_DATA: begin
            s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
            if (s_r.rx_cnt == '0) begin
               s_nxt.rx_sh  = shv;
               s_nxt.rx_cnt = s_r.baud;
               s_nxt.rx_bit = s_r.rx_bit + 1'b1;
               if (s_r.rx_bit == last_bit) begin
                  s_nxt.rx_st = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
            if (s_r.rx_cnt == '0) begin
               done        = 1'b1;
               fe          = ~dt;
               s_nxt.rx_st = RX_IDLE;
            end
         end
         default: s_nxt.rx_st = RX_IDLE;
      endcase
      if (s_r.rx_st == RX_STOP) begin
         word = align(s_r.rx_sh, s_r.ctl[BIT_NINE_EN]);
      end

      // an unread word blocks the new one and latches the overrun
      if (done) begin
         if (s_nxt.rx_full) begin
            s_nxt.overrun_error = 1'b1;
         end else begin
            s_nxt.rx_hold  = word[7:0];
            s_nxt.rx_ninth = word[8];
            s_nxt.rx_full  = 1'b1;
            s_nxt.framing_error     = fe;
         end
      end
      if (!s_nxt.ctl[BIT_CONT_RX]) begin
         s_nxt.overrun_error = 1'b0;
      end
      if (!s_nxt.ctl[BIT_PORT_EN]) begin
         s_nxt.tx_st    = TX_IDLE;
         s_nxt.tx_pin   = 1'b1;
         s_nxt.tx_brk   = 1'b0;
         s_nxt.brk_pend = 1'b0;
         s_nxt.rx_st    = RX_IDLE;
         s_nxt.rx_bit   = '0;
         s_nxt.rx_full  = 1'b0;
         s_nxt.framing_error     = 1'b0;
         s_nxt.overrun_error     = 1'b0;
      end
      // level interrupt doubles as the wake request while asleep
      s_nxt.irq  = s_nxt.rx_full & s_nxt.ctl[BIT_RX_IRQ_EN];
      s_nxt.room = f_in_ready;
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_r        <= '0;
         s_r.ctl    <= CTL_RST;
         s_r.baud   <= BAUD_RST;
         s_r.tx_st  <= TX_IDLE;
         s_r.tx_pin <= 1'b1;
         s_r.rx_st  <= RX_IDLE;
         s_r.dt_s   <= 2'h3;
         s_r.dt_q   <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

//--- hw/esp_far.sv
`timescale 1ns/100ps
`default_nettype none
module esp_far
   import esp_pkg::*;
#(
   parameter int HALF_CYC = CK_HALF_CYC,
   parameter int BIT_CLKS = BIT_CYC
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // clocked words to send
   input  wire logic       send_valid,
   output logic            send_ready,
   input  wire logic [8:0] send_data,
   input  wire logic       send_nine,
   // holds the data line low, a break seen by the port
   input  wire logic       break_hold,
   // characters received from the port
   output logic            recv_valid,
   output logic [7:0]      recv_data,
   output logic            recv_framing_error,
   // serial link
   esp_link_if.far         link
);
   localparam logic [3:0]  HALF_M1 = 4'(HALF_CYC - 1);
   localparam logic [15:0] BIT_M1  = 16'(BIT_CLKS - 1);

   typedef struct packed {
      esp_ck_state_type ck_st;
      logic [8:0]       sh;
      logic [3:0]       last;
      logic [3:0]       bitn;
      logic [3:0]       cnt;
      logic             ck;
      logic             dt;
      logic             ready;
      esp_rx_state_type rs;
      logic [7:0]       rsh;
      logic [15:0]      rcnt;
      logic [3:0]       rbit;
      logic [1:0]       tx_s;
      logic             tx_q;
      logic             rvalid;
      logic [7:0]       rdata;
      logic             rferr;
   } esp_far_st_type;

   esp_far_st_type s_r;
   esp_far_st_type s_nxt;
   logic           tx;

   assign send_ready  = s_r.ready;
   assign recv_valid  = s_r.rvalid;
   assign recv_data   = s_r.rdata;
   assign recv_framing_error   = s_r.rferr;
   assign link.ser_ck = s_r.ck;
   assign link.ser_dt = s_r.dt;

   always_comb begin
      s_nxt        = s_r;
      s_nxt.tx_s   = {s_r.tx_s[0], link.ser_tx};
      s_nxt.tx_q   = s_r.tx_s[1];
      s_nxt.rvalid = 1'b0;
      tx           = s_r.tx_s[1];

      // ----------------------------------------------------------------
      // clocked master: data changes while the clock is low
      // ----------------------------------------------------------------
      case (s_r.ck_st)
         CK_IDLE: begin
            s_nxt.ck = 1'b0;
            s_nxt.dt = ~break_hold;
            if (send_valid && s_r.ready) begin
               s_nxt.sh    = send_data;
               s_nxt.last  = send_nine ? NINE_LAST : DATA_LAST;
               s_nxt.bitn  = '0;
               s_nxt.dt    = send_data[0];
               s_nxt.cnt   = HALF_M1;
               s_nxt.ready = 1'b0;
               s_nxt.ck_st = CK_LOW;
            end
         end
         CK_LOW: begin
            s_nxt.cnt = s_r.cnt - 1'b1;
            if (s_r.cnt == '0) begin
               s_nxt.ck    = 1'b1;
               s_nxt.cnt   = HALF_M1;
               s_nxt.ck_st = CK_HIGH;
            end
         end
         CK_HIGH: begin
            s_nxt.cnt = s_r.cnt - 1'b1;
            if (s_r.cnt == '0) begin
               s_nxt.ck  = 1'b0;
               s_nxt.cnt = HALF_M1;
               if (s_r.bitn == s_r.last) begin
                  s_nxt.dt    = 1'b1;
                  s_nxt.ready = 1'b1;
                  s_nxt.ck_st = CK_IDLE;
               end else begin
                  s_nxt.bitn  = s_r.bitn + 1'b1;
                  s_nxt.sh    = {1'b0, s_r.sh[8:1]};
                  s_nxt.dt    = s_r.sh[1];
                  s_nxt.ck_st = CK_LOW;
               end
            end
         end
         default: s_nxt.ck_st = CK_IDLE;
      endcase

      // ----------------------------------------------------------------
      // character receiver, 8 data bits
      // ----------------------------------------------------------------
      case (s_r.rs)
         RX_IDLE: begin
            if (s_r.tx_q && !tx) begin
               s_nxt.rs   = RX_START;
               s_nxt.rcnt = BIT_M1 >> 1;
            end
         end
         RX_START: begin
            s_nxt.rcnt = s_r.rcnt - 1'b1;
            if (s_r.rcnt == '0) begin
               s_nxt.rs   = tx ? RX_IDLE : RX_DATA;
               s_nxt.rcnt = BIT_M1;
               s_nxt.rbit = '0;
            end
         end
         RX_DATA: begin
            s_nxt.rcnt = s_r.rcnt - 1'b1;
            if (s_r.rcnt == '0) begin
               s_nxt.rsh  = {tx, s_r.rsh[7:1]};
               s_nxt.rcnt = BIT_M1;
               s_nxt.rbit = s_r.rbit + 1'b1;
               if (s_r.rbit == DATA_LAST) begin
                  s_nxt.rs = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            s_nxt.rcnt = s_r.rcnt - 1'b1;
            if (s_r.rcnt == '0) begin
               s_nxt.rvalid = 1'b1;
               s_nxt.rdata  = s_r.rsh;
               s_nxt.rferr  = ~tx;
               // a break keeps the line low; wait for it to return high
               s_nxt.rs     = RX_IDLE;
            end
         end
         default: s_nxt.rs = RX_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_r       <= '0;
         s_r.ck_st <= CK_IDLE;
         s_r.dt    <= 1'b1;
         s_r.ready <= 1'b1;
         s_r.rs    <= RX_IDLE;
         s_r.tx_s  <= 2'h3;
         s_r.tx_q  <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

//--- hw/esp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module esp_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         reset_n,
   input  wire logic         flush,
   // filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   // depth must be a power of two so the pointers wrap by themselves
   localparam int AW = $clog2(D);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL = CW'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [CW-1:0]       cnt;
   } esp_fifo_st_type;

   esp_fifo_st_type s_r;
   esp_fifo_st_type s_nxt;
   logic            push;
   logic            pop;

   assign in_ready  = s_r.cnt != FULL;
   assign out_valid = s_r.cnt != '0;
   assign out_data  = s_r.mem[s_r.rp];

   always_comb begin
      s_nxt = s_r;
      push  = in_valid & in_ready;
      pop   = out_valid & out_ready;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp          = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
      if (flush) begin
         s_nxt.wp  = '0;
         s_nxt.rp  = '0;
         s_nxt.cnt = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

//--- hw/esp_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface esp_link_if;
   logic ser_tx;
   logic ser_dt;
   logic ser_ck;
   modport dev (output ser_tx, input ser_dt, input ser_ck);
   modport far (input ser_tx, output ser_dt, output ser_ck);
endinterface
`default_nettype wire

//--- hw/esp_pkg.sv
package esp_pkg;

   // ----------------------------------------------------------------
   // software port and register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam int REG_W  = 16;
   localparam int CTL_W  = 11;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_TXD  = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_RXD  = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_BAUD = 3'h4;

   // control register fields
   localparam int BIT_TX_EN       = 0;
   localparam int BIT_SEND_BREAK  = 1;
   localparam int BIT_PORT_EN     = 2;
   localparam int BIT_NINE_EN     = 3;
   localparam int BIT_SINGLE_RX   = 4;
   localparam int BIT_CONT_RX     = 5;
   localparam int BIT_CLOCKED     = 6;
   localparam int BIT_CLK_MASTER  = 7;
   localparam int BIT_WAKE_EN     = 8;
   localparam int BIT_AUTOBAUD_EN = 9;
   localparam int BIT_RX_IRQ_EN   = 10;

   // status register fields
   localparam int ST_TX_SHIFT_EMPTY = 0;
   localparam int ST_TX_BUF_EMPTY   = 1;
   localparam int ST_RX_DONE        = 2;
   localparam int ST_FRAME_ERR      = 3;
   localparam int ST_OVERRUN        = 4;
   localparam int ST_NINTH          = 5;

   localparam logic [CTL_W-1:0] CTL_RST  = 11'h000;
   localparam logic [REG_W-1:0] BAUD_RST = 16'h0027;

   // ----------------------------------------------------------------
   // framing and timing
   // ----------------------------------------------------------------
   localparam logic [3:0] BREAK_LAST = 4'hB;
   localparam logic [3:0] DATA_LAST  = 4'h7;
   localparam logic [3:0] NINE_LAST  = 4'h8;
   localparam int TXF_W     = 9;
   localparam int TXF_DEPTH = 8;
   localparam int CLK_PERIOD_NS     = 25;
   localparam int LINK_CK_PERIOD_NS = 200;
   localparam int CK_HALF_CYC = LINK_CK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int BIT_CYC     = int'(BAUD_RST) + 1;

   // ----------------------------------------------------------------
   // state encodings
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      TX_IDLE = 4'h1, TX_START = 4'h2, TX_DATA = 4'h4, TX_STOP = 4'h8
   } esp_tx_state_type;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_STOP = 5'h08, RX_WAKE = 5'h10
   } esp_rx_state_type;

   typedef enum logic [2:0] {
      CK_IDLE = 3'h1, CK_LOW = 3'h2, CK_HIGH = 3'h4
   } esp_ck_state_type;

endpackage

//--- verif/esp_link_chk.sv
`timescale 1ns/100ps
`default_nettype none
module esp_link_chk (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // link
   input wire logic ser_tx,
   input wire logic ser_dt,
   input wire logic ser_ck
);
   // run lengths of ser_tx; the high count saturates so idle never wraps
   logic [9:0] lo_r;
   logic [7:0] hi_r;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         lo_r <= 10'h000;
         hi_r <= 8'hFF;
      end else begin
         lo_r <= ser_tx ? 10'h000 : lo_r + 10'h001;
         hi_r <= ser_tx ? hi_r + {7'h00, hi_r != 8'hFF} : 8'h00;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_brk; $rose(ser_tx) |-> lo_r <= 10'h208; endproperty
   a_brk: assert property (p_brk) else $error("low run too long");
   property p_b13; $rose(ser_tx) && lo_r > 10'h168 |-> lo_r == 10'h208; endproperty
   a_b13: assert property (p_b13) else $error("break length wrong");
   property p_bit; $rose(ser_tx) |-> lo_r % 10'h028 == 10'h000; endproperty
   a_bit: assert property (p_bit) else $error("low run off bit grid");
   property p_hi; $fell(ser_tx) |-> hi_r >= 8'h28; endproperty
   a_hi: assert property (p_hi) else $error("high run short");
   property p_nxt; $rose(ser_tx) && lo_r == 10'h208 |-> ##[40:48] !ser_tx; endproperty
   a_nxt: assert property (p_nxt) else $error("no byte after break");
   property p_ckh; $rose(ser_ck) |-> ser_ck[*4] ##1 !ser_ck; endproperty
   a_ckh: assert property (p_ckh) else $error("clock high phase wrong");
   property p_ckl; $fell(ser_ck) |-> !ser_ck[*4]; endproperty
   a_ckl: assert property (p_ckl) else $error("clock low phase short");
   property p_dt; ser_ck |-> $stable(ser_dt); endproperty
   a_dt: assert property (p_dt) else $error("data moved with clock high");
   c_brk: cover property ($rose(ser_tx) && lo_r == 10'h208);
   c_chr: cover property ($rose(ser_tx) && lo_r == 10'h028);
   c_ck: cover property ($rose(ser_ck));
endmodule
`default_nettype wire

//--- verif/serial_break_and_sync_slave_rx_test.sv
`timescale 1ns/100ps
`default_nettype none
module serial_break_and_sync_slave_rx_test;
   import esp_pkg::*;
   logic              clock = 1'b0, reset_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
   logic [ADDR_W-1:0] sw_addr = '0;
   logic [15:0]       sw_wdata = '0, sw_rdata, d;
   logic              rx_irq, tx_room, send_valid = 1'b0, send_ready, send_nine = 1'b1, break_hold = 1'b0;
   logic [8:0]        send_data = '0;
   logic              recv_valid, recv_framing_error;
   logic [7:0]        recv_data;
   int                n_mismatch = 0, n_compared = 0, i;
   // word sent, then data byte expected
   logic [16:0]       rows [4] = '{17'h1A5A5, 17'h05A5A, 17'h1FFFF, 17'h00000};
   always #12.5 clock = ~clock;
   esp_link_if i_esp_link_if ();
   esp_dev i_esp_dev (.clock, .reset_n, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .rx_irq, .tx_room,
      .link(i_esp_link_if));
   esp_far i_esp_far (.clock, .reset_n, .send_valid, .send_ready, .send_data, .send_nine, .break_hold,
      .recv_valid, .recv_data, .recv_framing_error, .link(i_esp_link_if));
   esp_link_chk i_esp_link_chk (.clock, .reset_n, .ser_tx(i_esp_link_if.ser_tx),
      .ser_dt(i_esp_link_if.ser_dt), .ser_ck(i_esp_link_if.ser_ck));
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
      @(posedge clock);
      sw_wr <= 1'b1;
      sw_addr <= a;
      sw_wdata <= v;
      @(posedge clock);
      sw_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clock);
      sw_rd <= 1'b1;
      sw_addr <= a;
      @(posedge clock);
      sw_rd <= 1'b0;
      @(posedge clock);
      d = sw_rdata;
   endtask
   // 0 irq, 1 far character, 2 far ready; a lapsed bound ends the run
   task automatic wait_sig(input int s);
      for (int k = 0; k < 5000; k++) begin
         @(posedge clock);
         if (s == 0 ? rx_irq : s == 1 ? recv_valid : send_ready) return;
      end
      n_mismatch++;
      tally_and_finish;
   endtask
   task automatic send(input logic [8:0] w);
      @(posedge clock);
      send_valid <= 1'b1;
      send_data <= w;
      wait_sig(2);
      send_valid <= 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      wr(ADDR_CTRL, 16'h047C);
      for (i = 0; i < 4; i++) begin
         send(rows[i][16:8]);
         wait_sig(0);
         rd(ADDR_STAT);
         chk(d[ST_NINTH], rows[i][16]);
         rd(ADDR_RXD);
         chk(d, {8'h00, rows[i][7:0]});
         chk(rx_irq, 1'b0);
         $display("row %0d", i);
      end
      send(9'h011);
      send(9'h022);
      send(9'h033);
      wait_sig(2);
      rd(ADDR_STAT);
      chk(d[ST_OVERRUN], 1'b1);
      wr(ADDR_CTRL, 16'h044C);
      rd(ADDR_STAT);
      chk(d[ST_OVERRUN], 1'b0);
      rd(ADDR_RXD);
      chk(d, 16'h0011);
      $display("overrun");
      wr(ADDR_CTRL, 16'h0424);
      break_hold <= 1'b1;
      repeat (600) @(posedge clock);
      break_hold <= 1'b0;
      wait_sig(0);
      rd(ADDR_STAT);
      chk(d[3:2], 2'b11);
      rd(ADDR_RXD);
      chk(d, 16'h0000);
      $display("break in");
      wr(ADDR_CTRL, 16'h0724);
      break_hold <= 1'b1;
      repeat (40) @(posedge clock);
      break_hold <= 1'b0;
      wait_sig(0);
      rd(ADDR_CTRL);
      chk(d, 16'h0624);
      rd(ADDR_RXD);
      chk(d, 16'h0000);
      $display("wake");
      wr(ADDR_CTRL, 16'h0007);
      wr(ADDR_TXD, 16'h00AA);
      wr(ADDR_TXD, 16'h0055);
      rd(ADDR_STAT);
      chk(d[1:0], 2'b10);
      chk(tx_room, 1'b1);
      wait_sig(1);
      chk({recv_framing_error, recv_data}, 16'h0100);
      wait_sig(1);
      chk({recv_framing_error, recv_data}, 16'h0055);
      rd(ADDR_CTRL);
      chk(d, 16'h0005);
      $display("break out");
      reset_n <= 1'b0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      rd(ADDR_CTRL);
      chk(d, {5'h00, CTL_RST});
      rd(ADDR_BAUD);
      chk(d, BAUD_RST);
      chk(tx_room, 1'b1);
      $display("reset");
      tally_and_finish;
   end
endmodule
`default_nettype wire
